// File: hw/isolator_power_good_sequencer.sv
// power-good, low-power and pull-up mirroring logic for a usb port isolator
// assumes supply monitors, reference clock and line levels arrive unsynchronised
// Overview of operation
// - reference clock retimes high speed data
// - oscillator running within 0.3 ms
// - reference copy forwarded across barrier
// - downstream waits low-power until upstream powered
// - supply-ok needs both supplies and clock
// - supply loss drops supply-ok after settling
// - mirror downstream pull-up onto upstream line
// - idle or detach 3 ms enters low power
`timescale 1ns/100ps
`default_nettype none
module isolator_power_good_sequencer
  import iso_seq_pkg::*;
#(
  parameter int unsigned OSC_LIMIT  = OSC_START_CYC,
  parameter int unsigned IDLE_LIMIT = IDLE_CYC
) (
  // clock and reset
  input  wire logic      sys_clk_in,
  input  wire logic      reset_in,
  // supply monitors
  input  wire supply_t   undervoltage_lockout_in,
  // reference clock input, sampled as a level
  input  wire logic      ref_clk_in,
  // usb lines
  input  wire usb_pair_t downstream_line_in,
  input  wire usb_pair_t upstream_line_in,
  // outputs
  output logic           supply_ok_out,
  output logic           low_power_out,
  output logic           osc_enable_out,
  output logic           osc_fault_out,
  output logic           ref_copy_out,
  output logic           retime_enable_out,
  output usb_pair_t      upstream_pullup_out
);
  // synchroniser stages
  logic [7:0]  sync_a;
  logic [7:0]  sync_b;
  logic        ref_prev;       // previous synced reference level
  logic [3:0]  edge_cnt;       // reference edges seen
  logic [3:0]  loss_cnt;       // cycles since last reference edge
  logic        clk_valid;      // reference judged present
  logic [3:0]  settle_cnt;     // settling delay counter
  logic [15:0] idle_cnt;       // bus idle timer
  logic [12:0] osc_cnt;        // oscillator start timer
  seq_state_t  state;
  seq_state_t  next_state;

  supply_t   sup;
  usb_pair_t dn;
  usb_pair_t up;
  usb_pair_t dn_prev;    // downstream lines one cycle back
  logic      ref_s;
  logic      ref_edge;
  logic      both_good;
  logic      bus_active;
  logic      attached;
  assign sup      = supply_t'(sync_b[3:0]);
  assign ref_s    = sync_b[4];
  assign dn       = usb_pair_t'(sync_b[6:5]);
  assign up       = usb_pair_t'({sync_b[7], 1'b0});
  assign ref_edge = ref_s & ~ref_prev;
  // supplies on each side are good when core and bus monitors both read high
  assign both_good = sup.upstream_core_supply & sup.upstream_bus_supply &
                     sup.downstream_core_supply & sup.downstream_bus_supply;
  assign attached  = dn.dp | dn.dm;
  // any toggle on the downstream lines, or upstream dp held high, counts as traffic; compared against a later
  // copy, never the first stage, which may still be settling
  assign bus_active = (dn != dn_prev) | up.dp;

  // two flops on every asynchronous input except reset and upstream dm; first stage feeds only the second
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_a  <= 8'h00;
      sync_b  <= 8'h00;
      dn_prev <= 2'h0;
    end else begin
      sync_a  <= {upstream_line_in.dp, downstream_line_in,
                  ref_clk_in, undervoltage_lockout_in};
      sync_b  <= sync_a;
      dn_prev <= dn;
    end
  end
  // reference clock presence detector
  // the reference is far faster than this sampler in silicon; here it is a
  // coarse activity check, so a stuck pin is always caught
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ref_prev  <= 1'b0;
      edge_cnt  <= 4'h0;
      loss_cnt  <= 4'h0;
      clk_valid <= 1'b0;
    end else begin
      ref_prev <= ref_s;
      if (ref_edge) begin
        loss_cnt <= 4'h0;
        if (edge_cnt != CLK_GOOD_EDGES)
          edge_cnt <= edge_cnt + 4'h1;
      end else if (loss_cnt != CLK_LOSS_CYC) begin
        loss_cnt <= loss_cnt + 4'h1;
      end else begin
        edge_cnt <= 4'h0;
      end
      clk_valid <= (edge_cnt == CLK_GOOD_EDGES) && (loss_cnt != CLK_LOSS_CYC);
    end
  end

  // sequencing state register
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) state <= ST_OFF;
    else          state <= next_state;
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (both_good) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!both_good)     next_state = ST_OFF;
        else if (clk_valid) next_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!both_good || !clk_valid) next_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settle_cnt == SETTLE_CYC) next_state = ST_OFF;
      end
      default: next_state = ST_OFF;
    endcase
  end

  // settling counter runs only in the settle state
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in)              settle_cnt <= 4'h0;
    else if (state == ST_SETTLE) settle_cnt <= settle_cnt + 4'h1;
    else                       settle_cnt <= 4'h0;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) supply_ok_out <= SUPPLY_OK_RST;
    else          supply_ok_out <= (next_state == ST_ACTIVE) ||
                                   (next_state == ST_SETTLE);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_cnt      <= 16'h0000;
      low_power_out <= LOW_POWER_RST;
    end else begin
      if (bus_active || (attached && low_power_out && state == ST_ACTIVE))
        idle_cnt <= 16'h0000;
      else if (idle_cnt != IDLE_LIMIT[15:0])
        idle_cnt <= idle_cnt + 16'h0001;
      if (state == ST_OFF || state == ST_WAIT && !both_good)
        low_power_out <= 1'b1;
      else if (idle_cnt == IDLE_LIMIT[15:0] && !bus_active)
        low_power_out <= 1'b1;
      else if (bus_active || state == ST_WAIT)
        low_power_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_cnt       <= 13'h0000;
      osc_fault_out <= 1'b0;
    end else if (low_power_out || clk_valid) begin
      osc_cnt <= 13'h0000;
      if (clk_valid) osc_fault_out <= 1'b0;
    end else if (osc_cnt != OSC_LIMIT[12:0]) begin
      osc_cnt <= osc_cnt + 13'h0001;
    end else begin
      osc_fault_out <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      osc_enable_out    <= 1'b0;
      ref_copy_out      <= 1'b0;
      retime_enable_out <= 1'b0;
    end else begin
      osc_enable_out    <= ~low_power_out | (state == ST_WAIT);
      ref_copy_out      <= ref_s & clk_valid;
      retime_enable_out <= clk_valid & (state == ST_ACTIVE);
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) upstream_pullup_out <= 2'h0;
    else if (both_good) upstream_pullup_out <= dn;
    else upstream_pullup_out <= 2'h0;
  end

  // checks
  a_ok_needs_all: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(supply_ok_out) |-> $past(both_good) && $past(clk_valid))
    else $error("supply ok rose without supplies and clock");
  a_ok_drop_settle: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    (state == ST_ACTIVE && !both_good) |=> supply_ok_out [*5] ##1 !supply_ok_out)
    else $error("supply ok did not fall after settling");
  a_lp_until_up: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state == ST_OFF) |=> low_power_out)
    else $error("left low power before upstream powered");
  a_pullup_mirror: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    both_good && $stable(both_good) |=> upstream_pullup_out == $past(dn))
    else $error("upstream pull-up does not mirror downstream");
  a_ok_no_glitch: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $rose(supply_ok_out) |=> supply_ok_out)
    else $error("supply ok pulsed for one cycle");
  a_retime_clk: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    retime_enable_out |-> $past(clk_valid))
    else $error("retime enabled without reference");
  a_copy_valid: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    ref_copy_out |-> $past(clk_valid))
    else $error("reference copy sent while invalid");
  a_osc_fault: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    osc_fault_out |-> !low_power_out || $past(osc_fault_out))
    else $error("oscillator fault raised in low power");
  a_idle_enter: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (idle_cnt == IDLE_LIMIT[15:0] && !bus_active) |=> low_power_out)
    else $error("idle timeout did not enter low power");
  c_power_up: cover property (@(posedge sys_clk_in) $rose(supply_ok_out));
  c_power_loss: cover property (@(posedge sys_clk_in) $fell(supply_ok_out));
  c_attach: cover property (@(posedge sys_clk_in) $rose(upstream_pullup_out.dp));
  c_idle: cover property (@(posedge sys_clk_in) $rose(low_power_out));
endmodule
`default_nettype wire

// File: hw/iso_seq_pkg.sv
// shared constants and carriers for the isolator power-good sequencer
// assumes a single 20 MHz system clock and asynchronous active-high reset
package iso_seq_pkg;
  // system clock rate in hz
  localparam int unsigned CLK_HZ           = 20_000_000;
  // oscillator start-up limit in microseconds
  localparam int unsigned OSC_START_US     = 300;
  // longest time rounds down
  localparam int unsigned OSC_START_CYC    = OSC_START_US * (CLK_HZ / 1_000_000);
  // bus idle time before low power, in microseconds
  localparam int unsigned IDLE_US          = 3000;
  // least time; the integer divide rounds down
  localparam int unsigned IDLE_CYC         = IDLE_US * (CLK_HZ / 1_000_000);
  // reference clock edges needed to call it valid
  localparam logic [3:0]  CLK_GOOD_EDGES   = 4'h8;
  // sys cycles without a reference edge before it is declared lost
  localparam logic [3:0]  CLK_LOSS_CYC     = 4'h8;
  // settle count that ends settling; supply-ok falls one cycle later
  localparam logic [3:0]  SETTLE_CYC       = 4'h4;
  // reset values
  localparam logic        SUPPLY_OK_RST    = 1'b0;
  localparam logic        LOW_POWER_RST    = 1'b1;

  // supply monitor indications, high means above threshold
  typedef struct packed {
    logic upstream_core_supply;
    logic upstream_bus_supply;
    logic downstream_core_supply;
    logic downstream_bus_supply;
  } supply_t;

  // one pair of usb data lines, high means line is high
  typedef struct packed {
    logic dp;
    logic dm;
  } usb_pair_t;

  // power sequencing states
  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_SETTLE = 4'b1000
  } seq_state_t;
endpackage

// File: verification/ref_source_model.sv
// far-side model: reference clock source and side supply rails
// assumes the bench drives rail and run requests at the falling edge
`timescale 1ns/100ps
`default_nettype none
module ref_source_model
  import iso_seq_pkg::*;
(
  // clock
  input  wire logic    sys_clk_in,
  // requests from the bench
  input  wire logic    run_in,
  input  wire supply_t rails_in,
  // towards the design
  output supply_t      rails_out,
  output logic         ref_clk_out
);
  logic [1:0] div;  // slows the reference so two-flop sampling sees it
  // rails follow the request directly
  assign rails_out = rails_in;
  initial begin
    div = 2'h0;
    ref_clk_out = 1'b0;
  end
  // fixed period, gated by both rails
  // acts on the rising edge so the bench's falling-edge writes never race it
  always @(posedge sys_clk_in) begin
    if (run_in && rails_in.downstream_bus_supply &&
        rails_in.downstream_core_supply) begin
      div <= div + 2'h1;
      if (div[0]) begin
        ref_clk_out <= ~ref_clk_out;
      end
    end else begin
      // clock stands still low outside use
      div <= 2'h0;
      ref_clk_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verification/isolator_power_good_sequencer_tb.sv
// self-checking bench for the power-good sequencer
// assumes short oscillator and idle limits for a quick run
`timescale 1ns/100ps
`default_nettype none
module isolator_power_good_sequencer_tb;
  import iso_seq_pkg::*;
  localparam int OSC = 50;  // shortened oscillator limit
  localparam int IDL = 100; // shortened idle limit
  logic      sys_clk = 1'b0;
  logic      reset = 1'b1;
  logic      run = 1'b0;
  supply_t   rails = 4'h0;
  supply_t   rails_seen;
  logic      ref_clk;
  usb_pair_t dn = 2'h0;
  usb_pair_t up = 2'h0;
  logic      ok, lp, osc_en, osc_flt, ref_cp, rt_en;
  usb_pair_t pu;
  int        n_fail = 0;
  int        checks_done = 0;
  int        t;
  always #25 sys_clk = ~sys_clk;
  ref_source_model i_ref_source_model (.sys_clk_in(sys_clk), .run_in(run),
    .rails_in(rails), .rails_out(rails_seen), .ref_clk_out(ref_clk));
  isolator_power_good_sequencer #(.OSC_LIMIT(OSC), .IDLE_LIMIT(IDL))
    i_isolator_power_good_sequencer (.sys_clk_in(sys_clk),
    .reset_in(reset), .undervoltage_lockout_in(rails_seen),
    .ref_clk_in(ref_clk),
    .downstream_line_in(dn), .upstream_line_in(up), .supply_ok_out(ok),
    .low_power_out(lp), .osc_enable_out(osc_en), .osc_fault_out(osc_flt),
    .ref_copy_out(ref_cp), .retime_enable_out(rt_en),
    .upstream_pullup_out(pu));
  // single-bit compare
  task chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // line pair compare
  task chk2(input string what, input usb_pair_t exp, input usb_pair_t got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // bounded wait on supply-ok (sel 0) or low power (sel 1)
  task wait_on(input int sel, input logic v, input int lim);
    t = 0;
    while (((sel == 0) ? ok : lp) !== v && t < lim) begin
      @(negedge sys_clk);
      t++;
    end
    chk("wait reached", 1'b1, t < lim);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // downstream alone stays quiet, clock even running
  task t_one_side;
    rails = 4'h3;
    run = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk("low_power", 1'b1, lp);
    chk("supply_ok", 1'b0, ok);
    $display("t_one_side done");
  endtask
  // all rails but no reference: fault after the start limit
  task t_no_clock;
    run = 1'b0;
    dn = 2'h2;
    // old reference must age out; the attach restarts the idle timer
    repeat (16) @(negedge sys_clk);
    rails = 4'hf;
    repeat (OSC + 20) @(negedge sys_clk);
    chk("supply_ok", 1'b0, ok);
    chk("osc_enable", 1'b1, osc_en);
    chk("osc_fault", 1'b1, osc_flt);
    $display("t_no_clock done");
  endtask
  // clock arrives: ok, retime, copy and pull-up mirror
  task t_power_up;
    int n_hi;
    int n_lo;
    n_hi = 0;
    n_lo = 0;
    dn = 2'h2;
    run = 1'b1;
    wait_on(0, 1'b1, 60);
    // retiming is registered one cycle after supply-ok
    @(negedge sys_clk);
    chk("retime_enable", 1'b1, rt_en);
    repeat (16) begin
      @(negedge sys_clk);
      if (ref_cp === 1'b1) n_hi++;
      if (ref_cp === 1'b0) n_lo++;
    end
    chk("ref_copy toggles", 1'b1, n_hi > 3 && n_lo > 3);
    chk2("pullup dp", 2'h2, pu);
    dn = 2'h1;
    repeat (6) @(negedge sys_clk);
    chk2("pullup dm", 2'h1, pu);
    $display("t_power_up done");
  endtask
  // reference lost then restored
  task t_clock_loss;
    run = 1'b0;
    wait_on(0, 1'b0, 30);
    run = 1'b1;
    wait_on(0, 1'b1, 60);
    $display("t_clock_loss done");
  endtask
  // upstream bus rail drops: settle then low, mirror refused
  task t_drop;
    rails = 4'hb;
    repeat (3) @(negedge sys_clk);
    chk("supply_ok settling", 1'b1, ok);
    wait_on(0, 1'b0, 20);
    chk2("pullup refused", 2'h0, pu);
    $display("t_drop done");
  endtask
  // detach for the idle limit, then reattach
  task t_idle;
    rails = 4'hf;
    dn = 2'h2;
    wait_on(0, 1'b1, 60);
    dn = 2'h0;
    wait_on(1, 1'b1, IDL + 20);
    // upstream resume wakes, then idle again
    up = 2'h2;
    wait_on(1, 1'b0, 20);
    up = 2'h0;
    wait_on(1, 1'b1, IDL + 20);
    dn = 2'h2;
    wait_on(1, 1'b0, 20);
    $display("t_idle done");
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    chk("reset low_power", LOW_POWER_RST, lp);
    chk("reset supply_ok", SUPPLY_OK_RST, ok);
    reset = 1'b0;
    t_one_side();
    t_no_clock();
    t_power_up();
    t_clock_loss();
    t_drop();
    t_idle();
    end_sim();
  end
endmodule
`default_nettype wire
